// file: hdl/pmc_pkg.sv
package pmc_pkg;
   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [8:0] ADDR_ENABLE = 9'h100;
   localparam logic [8:0] ADDR_SENS = 9'h101;
   localparam logic [8:0] ADDR_SC0 = 9'h102;
   localparam logic [8:0] ADDR_SC1 = 9'h103;
   localparam logic [8:0] ADDR_RANGE = 9'h104;
   // -------------------------------------------------------------
   // Codes and field positions
   // -------------------------------------------------------------
   localparam logic [7:0] ENGINE_ON_CODE = 8'h11;
   localparam logic [7:0] ENGINE_OFF_CODE = 8'h00;
   localparam int SC0_EXT_LO = 6;
   localparam int SC0_OFF_ACK = 5;
   localparam int SC0_PAUSE = 4;
   localparam int SC0_DIR_EN = 3;
   localparam int SC0_DIR = 2;
   localparam int SC0_MOTION = 1;
   localparam int SC0_SETTLED = 0;
   localparam int SC1_TICK = 7;
   localparam logic [7:0] SC1_WMASK = 8'hfd;
   localparam logic [2:0] RANGE_MASK = 3'h7;
   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] SENS_RST = 8'h00;
   localparam logic [7:0] SC0_RST = 8'h20;
   localparam logic [7:0] SC1_RST = 8'h00;
   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int SETTLE_TICKS_DEF = 2;
   localparam int BASE_SHIFT = 3;
   localparam int BUF_DEPTH = 8;
   typedef enum {ST_OFF, ST_SETTLE, ST_RUN} pmc_state_t;
endpackage

// file: hdl/pmc_sample_mem.sv
`timescale 1ns/1ps
// Small sample ring; read data registered
module pmc_sample_mem #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic mclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   // -------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------
   // No reset: contents are history only
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// file: hdl/pmc_engine.sv
`timescale 1ns/1ps
module pmc_engine
   import pmc_pkg::*;
#(
   parameter int SAMPLE_W = 10,
   parameter int SETTLE_TICKS = SETTLE_TICKS_DEF
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [8:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic conv_event,
   input wire logic [SAMPLE_W-1:0] conv_sample,
   output logic engine_active
);
   import pmc_pkg::*;

   localparam int AW = $clog2(BUF_DEPTH);

   typedef struct packed {
      logic [7:0] enable;
      logic [7:0] sens;
      logic [7:0] sc0;
      logic [7:0] sc1;
      logic [2:0] range;
      logic [7:0] rdata;
      logic [AW-1:0] wptr;
      logic [SAMPLE_W-1:0] base;
      logic [7:0] settle_cnt;
      logic [1:0] fill;
   } pmc_regs_t;

   pmc_regs_t q_r, q_nxt;
   pmc_state_t st_r, st_nxt;
   logic [SAMPLE_W-1:0] old_sample;

   // -------------------------------------------------------------
   // Helper arithmetic
   // -------------------------------------------------------------
   // Detection threshold from sensitivity, range and extended level
   function automatic logic [SAMPLE_W+1:0] thresh_f(input logic [7:0] sens,
         input logic [2:0] range, input logic [1:0] ext);
      logic [SAMPLE_W+1:0] t;
      logic [SAMPLE_W+1:0] rng;
      t = {{(SAMPLE_W-6){1'b0}}, sens} + (SAMPLE_W+2)'(1);
      rng = (SAMPLE_W+2)'(range) << (2'd3 - ext);
      t = t + rng;
      thresh_f = t >> ext;
   endfunction

   function automatic logic [SAMPLE_W:0] absdiff_f(input logic [SAMPLE_W-1:0] a,
         input logic [SAMPLE_W-1:0] b);
      absdiff_f = (a >= b) ? {1'b0, a - b} : {1'b0, b - a};
   endfunction

   // -------------------------------------------------------------
   // Sample history
   // -------------------------------------------------------------
   // Buffering keeps running while paused so recovery is quick
   pmc_sample_mem #(
      .WIDTH(SAMPLE_W),
      .DEPTH(BUF_DEPTH)
   ) u_mem (
      .mclk(mclk),
      .we(conv_event && st_r != ST_OFF),
      .waddr(q_r.wptr),
      .wdata(conv_sample),
      .raddr(q_r.wptr),
      .rdata(old_sample)
   );

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      logic [SAMPLE_W:0] dev;
      logic hit;
      logic pos;
      logic on_code;
      q_nxt = q_r;
      st_nxt = st_r;
      dev = '0;
      hit = 1'b0;
      pos = 1'b0;
      on_code = (q_r.enable == ENGINE_ON_CODE);
      // Software writes; engine-owned bits are read only
      if (reg_wr) begin
         case (reg_addr)
            ADDR_ENABLE: q_nxt.enable = reg_wdata;
            ADDR_SENS: q_nxt.sens = reg_wdata;
            ADDR_SC0: begin
               q_nxt.sc0[7:SC0_EXT_LO] = reg_wdata[7:SC0_EXT_LO];
               q_nxt.sc0[SC0_PAUSE] = reg_wdata[SC0_PAUSE];
               q_nxt.sc0[SC0_DIR_EN] = reg_wdata[SC0_DIR_EN];
               // Software may only clear the motion flag
               if (!reg_wdata[SC0_MOTION]) begin
                  q_nxt.sc0[SC0_MOTION] = 1'b0;
               end
            end
            ADDR_SC1: q_nxt.sc1 = reg_wdata & SC1_WMASK;
            ADDR_RANGE: q_nxt.range = reg_wdata[2:0] & RANGE_MASK;
            default: ;
         endcase
      end
      // Engine work happens only on a conversion event
      if (conv_event) begin
         case (st_r)
            ST_OFF: begin
               if (on_code) begin
                  q_nxt.sc0[SC0_OFF_ACK] = 1'b0;
                  q_nxt.sc0[SC0_SETTLED] = 1'b0;
                  q_nxt.sc0[SC0_MOTION] = 1'b0;
                  q_nxt.sc0[SC0_DIR] = 1'b0;
                  q_nxt.settle_cnt = '0;
                  q_nxt.fill = '0;
                  q_nxt.base = conv_sample;
                  st_nxt = ST_SETTLE;
               end
            end
            ST_SETTLE, ST_RUN: begin
               if (!on_code) begin
                  // Off code and reserved codes both halt the engine
                  q_nxt.sc0[SC0_OFF_ACK] = 1'b1;
                  q_nxt.sc0[SC0_SETTLED] = 1'b0;
                  st_nxt = ST_OFF;
               end else begin
                  q_nxt.wptr = q_r.wptr + AW'(1);
                  // Offset tracker: slow first-order follower
                  q_nxt.base = q_r.base + SAMPLE_W'((SAMPLE_W+1)'(signed'({1'b0, conv_sample}) -
                     signed'({1'b0, q_r.base})) >>> BASE_SHIFT);
                  if (q_r.fill != 2'd3) begin
                     q_nxt.fill = q_r.fill + 2'd1;
                  end
                  // Housekeeping on the one-second tick
                  if (q_r.sc1[SC1_TICK]) begin
                     q_nxt.sc1[SC1_TICK] = 1'b0;
                     if (st_r == ST_SETTLE) begin
                        q_nxt.settle_cnt = q_r.settle_cnt + 8'd1;
                        if (q_r.settle_cnt + 8'd1 >= 8'(SETTLE_TICKS)) begin
                           q_nxt.sc0[SC0_SETTLED] = 1'b1;
                           st_nxt = ST_RUN;
                        end
                     end
                  end
                  dev = absdiff_f(conv_sample, old_sample);
                  pos = (conv_sample >= old_sample);
                  hit = (SAMPLE_W+2)'(dev) > thresh_f(q_r.sens, q_r.range,
                     q_r.sc0[7:SC0_EXT_LO]) && q_r.fill == 2'd3;
                  // Pause and unsettled sensor both suppress detection
                  if (hit && st_r == ST_RUN && !q_r.sc0[SC0_PAUSE]
                        && q_r.sc0[SC0_SETTLED]) begin
                     // Direction latches only on a fresh flag; a pending flag keeps it
                     if (q_r.sc0[SC0_DIR_EN] && !q_nxt.sc0[SC0_MOTION]) begin
                        q_nxt.sc0[SC0_DIR] = pos;
                     end
                     q_nxt.sc0[SC0_MOTION] = 1'b1;
                  end
               end
            end
            default: st_nxt = ST_OFF;
         endcase
      end
      // Registered read data
      case (reg_addr)
         ADDR_ENABLE: q_nxt.rdata = q_r.enable;
         ADDR_SENS: q_nxt.rdata = q_r.sens;
         ADDR_SC0: q_nxt.rdata = q_r.sc0;
         ADDR_SC1: q_nxt.rdata = q_r.sc1;
         ADDR_RANGE: q_nxt.rdata = {5'h00, q_r.range};
         default: q_nxt.rdata = 8'h00;
      endcase
   end

   // -------------------------------------------------------------
   // State registers
   // -------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q_r <= '{enable: ENABLE_RST, sens: SENS_RST, sc0: SC0_RST, sc1: SC1_RST,
            range: 3'h0, rdata: 8'h00, wptr: '0, base: '0, settle_cnt: 8'h00,
            fill: 2'h0};
         st_r <= ST_OFF;
      end else begin
         q_r <= q_nxt;
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = q_r.rdata;
   assign engine_active = (st_r != ST_OFF);
endmodule

// file: sim/pmc_sensor_model.sv
`timescale 1ns/1ps
// Sensor behind the converter: one conversion every 16 clocks
module pmc_sensor_model #(
   parameter int W = 10
) (
   input wire logic mclk,
   input wire logic [W-1:0] level,
   output logic conv_event,
   output logic [W-1:0] conv_sample
);
   int cnt = 0;
   initial conv_event = 1'b0;
   initial conv_sample = '0;
   // Sample valid only with the pulse; junk between so stale data is never trusted
   always @(negedge mclk) begin
      cnt <= (cnt + 1) % 16;
      conv_event <= (cnt == 15);
      conv_sample <= (cnt == 15) ? level : ~conv_sample;
   end
endmodule

// file: sim/pmc_engine_sva.sv
`timescale 1ns/1ps
module pmc_engine_sva
   import pmc_pkg::*;
#(
   parameter int SAMPLE_W = 10,
   parameter int SETTLE_TICKS = SETTLE_TICKS_DEF
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [8:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic conv_event,
   input wire logic [SAMPLE_W-1:0] conv_sample,
   input wire logic engine_active
);
   logic [7:0] en_r;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Shadow of the enable register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         en_r <= ENABLE_RST;
      end else if (reg_wr && reg_addr == ADDR_ENABLE) begin
         en_r <= reg_wdata;
      end
   end
   // Two SC0 reads, no write between, engine steady
   sequence sc0_quiet;
      reg_addr == ADDR_SC0 && $stable(reg_addr) && !$past(reg_wr) && engine_active
         && $past(engine_active);
   endsequence
   act_conv_a: assert property (!conv_event |=> $stable(engine_active))
      else $error("active moved without conversion");
   act_code_a: assert property (conv_event |=> engine_active == $past(en_r == ENGINE_ON_CODE))
      else $error("active not per enable code");
   en_back_a: assert property (reg_addr == ADDR_ENABLE |=> reg_rdata == $past(en_r))
      else $error("enable readback wrong");
   off_ack_a: assert property (reg_addr == ADDR_SC0 && !engine_active |=> reg_rdata[SC0_OFF_ACK])
      else $error("off ack clear while off");
   off_settle_a: assert property (reg_addr == ADDR_SC0 && !engine_active |=> !reg_rdata[SC0_SETTLED])
      else $error("settled set while off");
   on_ack_a: assert property (reg_addr == ADDR_SC0 && engine_active |=> !reg_rdata[SC0_OFF_ACK])
      else $error("off ack set while on");
   motion_hold_a: assert property (sc0_quiet |=> reg_rdata[SC0_MOTION] >= $past(reg_rdata[SC0_MOTION]))
      else $error("motion cleared by engine");
   dir_hold_a: assert property (sc0_quiet ##0 reg_rdata[SC0_MOTION] |=> $stable(reg_rdata[SC0_DIR]))
      else $error("direction moved while motion held");
   cover property ($rose(engine_active));
   cover property ($fell(engine_active));
   cover property (reg_addr == ADDR_SC0 ##1 $rose(reg_rdata[SC0_MOTION]));
endmodule
bind pmc_engine pmc_engine_sva #(.SAMPLE_W(SAMPLE_W), .SETTLE_TICKS(SETTLE_TICKS)) i_sva (
   .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .conv_event(conv_event), .conv_sample(conv_sample),
   .engine_active(engine_active));

// file: sim/pir_motion_control_status_tb.sv
`timescale 1ns/1ps
module pir_motion_control_status_tb;
   import pmc_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [8:0] reg_addr = 9'h100;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic conv_event;
   logic [9:0] conv_sample;
   logic [9:0] level = 10'h200;
   logic engine_active;
   int miscompares = 0;
   int n_tests = 0;
   int cyc = 0;
   always #20 mclk = ~mclk;
   pmc_sensor_model i_sen (.mclk(mclk), .level(level), .conv_event(conv_event),
      .conv_sample(conv_sample));
   pmc_engine #(.SETTLE_TICKS(1)) i_dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_event(conv_event),
      .conv_sample(conv_sample), .engine_active(engine_active));
   // ----
   // Helpers
   // ----
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(negedge mclk);
      {reg_addr, reg_wr, reg_wdata} = {a, 1'b1, d};
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   // Read, then compare engine_active and the masked bits
   task automatic chk(input logic [8:0] a, input logic [7:0] m, input logic [8:0] e);
      @(negedge mclk);
      reg_addr = a;
      @(negedge mclk);
      n_tests++;
      if ({engine_active, reg_rdata & m} !== e) begin
         miscompares++;
         $display("CHECK FAILED %h exp %h got %h", a, e, {engine_active, reg_rdata & m});
      end
   endtask
   task automatic cv(input int n);
      repeat (n) @(posedge mclk iff conv_event);
      repeat (2) @(negedge mclk);
   endtask
   // Level moves on the rising edge, away from the sensor's sampling edge
   task automatic st(input logic [9:0] lv, input int n);
      @(posedge mclk);
      level = lv;
      cv(n);
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_reset;
      chk(ADDR_SC0, 8'hff, {1'b0, SC0_RST});
      chk(9'h1ff, 8'hff, 9'h000);
   endtask
   task automatic t_enable;
      wr(ADDR_SENS, 8'h10);
      wr(ADDR_SC0, 8'h08);
      wr(ADDR_ENABLE, ENGINE_ON_CODE);
      cv(1);
      chk(ADDR_SC0, 8'h21, 9'h100);
      st(10'h2c8, 12);
      chk(ADDR_SC0, 8'h02, 9'h100);
      st(10'h200, 10);
      wr(ADDR_SC1, 8'h80);
      cv(2);
      chk(ADDR_SC1, 8'h80, 9'h100);
      chk(ADDR_SC0, 8'h01, 9'h101);
   endtask
   task automatic t_motion;
      st(10'h2c8, 2);
      chk(ADDR_SC0, 8'h06, 9'h106);
      st(10'h2c8, 10);
      chk(ADDR_SC0, 8'h06, 9'h106);
      wr(ADDR_SC0, 8'h08);
      chk(ADDR_SC0, 8'h02, 9'h100);
      st(10'h200, 2);
      chk(ADDR_SC0, 8'h06, 9'h102);
      st(10'h200, 10);
      wr(ADDR_SC0, 8'h08);
   endtask
   // Code fe is too dull for the step; level 3 halves it thrice
   task automatic t_sens;
      wr(ADDR_SENS, 8'hfe);
      st(10'h2c8, 2);
      chk(ADDR_SC0, 8'h02, 9'h100);
      wr(ADDR_SC0, 8'hc8);
      cv(2);
      chk(ADDR_SC0, 8'h02, 9'h102);
      wr(ADDR_SENS, 8'h10);
      wr(ADDR_SC0, 8'h08);
      st(10'h200, 10);
      wr(ADDR_SC0, 8'h08);
   endtask
   task automatic t_pause;
      wr(ADDR_SC0, 8'h18);
      st(10'h2c8, 2);
      chk(ADDR_SC0, 8'h02, 9'h100);
      wr(ADDR_SC0, 8'h08);
      cv(2);
      chk(ADDR_SC0, 8'h02, 9'h102);
   endtask
   // Small falling step: range 7 hides it, level 3 finds it again
   task automatic t_range;
      st(10'h2c8, 8);
      wr(ADDR_SC0, 8'h00);
      wr(ADDR_RANGE, 8'h07);
      st(10'h288, 2);
      chk(ADDR_SC0, 8'h02, 9'h100);
      wr(ADDR_SC0, 8'hc0);
      cv(2);
      chk(ADDR_SC0, 8'h02, 9'h102);
      chk(ADDR_SC0, 8'h04, 9'h104);
   endtask
   task automatic t_off;
      wr(ADDR_ENABLE, 8'h22);
      cv(1);
      chk(ADDR_SC0, 8'h21, 9'h020);
      wr(ADDR_ENABLE, ENGINE_ON_CODE);
      cv(1);
      chk(ADDR_SC0, 8'h21, 9'h100);
      wr(ADDR_ENABLE, ENGINE_OFF_CODE);
      cv(1);
      chk(ADDR_SC0, 8'h21, 9'h020);
      chk(ADDR_ENABLE, 8'hff, 9'h000);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Hang guard, about three times the expected run
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 4000) begin
         miscompares++;
         report_and_stop;
      end
   end
   initial begin
      repeat (6) @(negedge mclk);
      rstn = 1'b1;
      t_reset;
      t_enable;
      t_motion;
      t_sens;
      t_pause;
      t_range;
      t_off;
      report_and_stop;
   end
endmodule
